// ### mdio_if.sv
// two-wire management link between station and device
`timescale 1ns/1ns
interface mdio_if;
  logic mdc;
  logic sta_out;
  logic sta_oe;
  logic phy_out;
  logic phy_oe;
  logic mdio;

  // line level: pulled high while nobody drives
  assign mdio = sta_oe ? sta_out : (phy_oe ? phy_out : 1'b1);

  modport sta (output mdc, output sta_out, output sta_oe, input mdio);
  modport phy (input mdc, input mdio, output phy_out, output phy_oe);
endinterface

// ### mdio_link_props.sv
// concurrent checks on the management link between station and device
`timescale 1ns/1ns
module mdio_link_props (
  // system clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // link wires
  input wire logic mdc,
  input wire logic sta_out,
  input wire logic sta_oe,
  input wire logic phy_out,
  input wire logic phy_oe,
  input wire logic mdio
);
  localparam int HALF     = mdio_pkg::MDC_HALF_CYC;
  // device drives the second turnaround bit and all 16 data bits
  localparam int OE_SPAN  = 34 * HALF;
  localparam int IDLE_LOW = 2 * HALF;

  logic        mdc_q;
  logic        mdio_q;
  logic [13:0] hist;
  int          oe_cnt;
  int          low_cnt;
  int          hi_cnt;

  // ==========================================================
  // helper logic
  // line taken one cycle before mdc rises, before the device reacts
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mdc_q  <= 1'h0;
      mdio_q <= 1'h1;
      hist   <= 14'h0000;
    end else begin
      mdc_q  <= mdc;
      mdio_q <= mdio;
      if (mdc && !mdc_q) begin
        hist <= {hist[12:0], mdio_q};
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      oe_cnt  <= 0;
      low_cnt <= 0;
      hi_cnt  <= 0;
    end else begin
      oe_cnt <= phy_oe ? oe_cnt + 1 : 0;
      hi_cnt <= mdc ? hi_cnt + 1 : 0;
      if (mdc) begin
        low_cnt <= 0;
      end else if (low_cnt <= IDLE_LOW) begin
        low_cnt <= low_cnt + 1;
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_no_contention: assert property (!(sta_oe && phy_oe))
    else $error("station and device drive the line together");
  a_phy_at_rise: assert property (
    ($changed(phy_out) || $changed(phy_oe)) |-> $rose(mdc))
    else $error("device output moved away from a rising mdc");
  a_sta_at_fall: assert property (
    ($changed(sta_out) || $changed(sta_oe)) |-> !mdc)
    else $error("station output moved while mdc high");
  a_read_turn: assert property (
    $rose(phy_oe) |-> $rose(mdc) && !phy_out && !sta_oe && mdio_q)
    else $error("read turnaround not released then driven low");
  a_read_header: assert property (
    $rose(phy_oe) |-> hist[13:5] ==
      {mdio_pkg::SFD_CODE, mdio_pkg::OP_READ, mdio_pkg::PHYAD_RESET})
    else $error("device answered a frame it should ignore");
  a_read_span: assert property ($fell(phy_oe) |-> oe_cnt == OE_SPAN)
    else $error("device drive span is not 17 bit times");
  a_idle_release: assert property (low_cnt > IDLE_LOW |-> !phy_oe)
    else $error("device drives the idle line");
  a_mdc_high: assert property ($fell(mdc) |-> hi_cnt == HALF)
    else $error("mdc high phase has the wrong length");

  cover property ($rose(phy_oe));
  cover property ($rose(sta_oe));
  cover property (low_cnt > IDLE_LOW && sta_oe);
endmodule

// ### mdio_phy_end.sv
// device end of the management link: frame decoder and register set
`timescale 1ns/1ns
module mdio_phy_end (
  // system clock domain
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // management link
  mdio_if.phy              LINK,
  // transaction reports, CLK domain
  output logic             RD_PULSE,
  output logic             WR_PULSE,
  output logic             IGN_PULSE,
  output logic [4:0]       EV_ADDR,
  output logic [15:0]      EV_DATA,
  output logic             PREAMBLE_OFF
);

  // ==========================================================
  // register attributes
  function automatic logic implemented(input logic [4:0] a);
    return mdio_pkg::IMPL_MASK[a];
  endfunction

  function automatic logic [15:0] rw_mask(input logic [4:0] a);
    logic [15:0] m;
    m = mdio_pkg::RW_NONE;
    if (a == mdio_pkg::REG_CTRL || a == mdio_pkg::REG_ANADV ||
        a == mdio_pkg::REG_NPTX || a == mdio_pkg::REG_TBOPS ||
        a == mdio_pkg::REG_XCTRL2) begin
      m = mdio_pkg::RW_ALL;
    end else if (a == mdio_pkg::REG_XCTRL) begin
      m = mdio_pkg::XCTRL_RW;
    end
    return m;
  endfunction

  function automatic logic [15:0] cw_mask(input logic [4:0] a);
    return (a == mdio_pkg::REG_STAT) ? mdio_pkg::STAT_CW
                                     : mdio_pkg::RW_NONE;
  endfunction

  function automatic logic [15:0] reset_value(input logic [4:0] a);
    logic [15:0] v;
    v = mdio_pkg::ZERO_RESET;
    if (a == mdio_pkg::REG_ID1) begin
      v = mdio_pkg::ID1_RESET;
    end else if (a == mdio_pkg::REG_ID2) begin
      v = mdio_pkg::ID2_RESET;
    end else if (a == mdio_pkg::REG_XCTRL) begin
      v = mdio_pkg::XCTRL_RESET;
    end
    return v;
  endfunction

  // ==========================================================
  // link domain reset
  // release waits for MDC edges; the preamble supplies them
  logic rst_meta;
  logic rst_link;

  always_ff @(posedge LINK.mdc or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_meta <= 1'b1;
      rst_link <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_link <= rst_meta;
    end
  end

  // ==========================================================
  // frame decoder
  // the mode pins of the MAC side are not looked at here
  mdio_pkg::phy_state_e state;
  logic [5:0]           bcnt;
  logic [1:0]           op;
  logic [4:0]           phyad_rx;
  logic [4:0]           regad;
  logic                 hit;
  logic [15:0]          sh;
  logic [15:0]          mreg [0:31];
  logic                 bit_in;
  logic                 suppress;
  logic                 override;
  logic [4:0]           my_addr;
  logic [1:0]           op_now;
  logic [4:0]           regad_now;
  logic [15:0]          wdata;
  logic                 frame_end;
  logic                 rd_hit;
  logic                 commit;

  assign bit_in    = LINK.mdio;
  assign suppress  = mreg[mdio_pkg::REG_STAT][mdio_pkg::SUPP_BIT];
  assign override  = mreg[mdio_pkg::REG_XCTRL][mdio_pkg::OVR_BIT];
  assign my_addr   = mreg[mdio_pkg::REG_XCTRL]
                         [mdio_pkg::PHYAD_MSB:mdio_pkg::PHYAD_LSB];
  assign op_now    = {op[0], bit_in};
  assign regad_now = {regad[3:0], bit_in};
  assign wdata     = {sh[14:0], bit_in};
  assign frame_end = (state == mdio_pkg::S_DATA) && (bcnt == 6'h0F);
  assign rd_hit    = hit && (op == mdio_pkg::OP_READ);
  assign commit    = frame_end && hit && (op == mdio_pkg::OP_WRITE)
                     && implemented(regad);

  // every field is sampled on the rising MDC edge
  always_ff @(posedge LINK.mdc or posedge rst_link) begin
    if (rst_link) begin
      state    <= mdio_pkg::S_IDLE;
      bcnt     <= 6'h00;
      op       <= 2'h0;
      phyad_rx <= 5'h00;
      regad    <= 5'h00;
      hit      <= 1'b0;
      sh       <= 16'h0000;
    end else begin
      case (state)
        mdio_pkg::S_IDLE: begin
          if (bit_in) begin
            if (bcnt != 6'(mdio_pkg::PRE_LEN)) begin
              bcnt <= bcnt + 6'h01;
            end
          end else begin
            bcnt <= 6'h00;
            // this zero is the first delimiter bit
            if (bcnt == 6'(mdio_pkg::PRE_LEN) || suppress) begin
              state <= mdio_pkg::S_SFD;
            end
          end
        end
        mdio_pkg::S_SFD: begin
          // a zero here breaks the delimiter
          state <= bit_in ? mdio_pkg::S_OP : mdio_pkg::S_IDLE;
        end
        mdio_pkg::S_OP: begin
          op <= op_now;
          if (bcnt == 6'h01) begin
            bcnt <= 6'h00;
            if (op_now == mdio_pkg::OP_READ ||
                op_now == mdio_pkg::OP_WRITE) begin
              state <= mdio_pkg::S_PHYAD;
            end else begin
              state <= mdio_pkg::S_IDLE;
            end
          end else begin
            bcnt <= bcnt + 6'h01;
          end
        end
        mdio_pkg::S_PHYAD: begin
          phyad_rx <= {phyad_rx[3:0], bit_in};
          if (bcnt == 6'(mdio_pkg::ADDR_LEN - 1)) begin
            bcnt  <= 6'h00;
            hit   <= ({phyad_rx[3:0], bit_in} == my_addr);
            state <= mdio_pkg::S_REGAD;
          end else begin
            bcnt <= bcnt + 6'h01;
          end
        end
        mdio_pkg::S_REGAD: begin
          regad <= regad_now;
          if (bcnt == 6'(mdio_pkg::ADDR_LEN - 1)) begin
            bcnt  <= 6'h00;
            state <= mdio_pkg::S_TA;
            // read source fetched before the turnaround
            sh    <= implemented(regad_now) ? mreg[regad_now]
                                            : mdio_pkg::DATA_ONES;
          end else begin
            bcnt <= bcnt + 6'h01;
          end
        end
        mdio_pkg::S_TA: begin
          // write turnaround bits are not checked
          if (bcnt == 6'h01) begin
            bcnt  <= 6'h00;
            state <= mdio_pkg::S_DATA;
          end else begin
            bcnt <= bcnt + 6'h01;
          end
        end
        mdio_pkg::S_DATA: begin
          sh <= wdata;
          if (frame_end) begin
            bcnt  <= 6'h00;
            // next frame may start on the very next edge
            state <= mdio_pkg::S_IDLE;
          end else begin
            bcnt <= bcnt + 6'h01;
          end
        end
        default: begin
          state <= mdio_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // line driver: updated on the rising edge, stable by the next
  always_ff @(posedge LINK.mdc or posedge rst_link) begin
    if (rst_link) begin
      LINK.phy_oe  <= 1'b0;
      LINK.phy_out <= 1'b0;
    end else if (rd_hit && state == mdio_pkg::S_TA) begin
      // first turnaround bit left released, second driven low
      LINK.phy_oe  <= 1'b1;
      LINK.phy_out <= (bcnt == 6'h00) ? 1'b0 : sh[15];
    end else if (rd_hit && state == mdio_pkg::S_DATA && !frame_end) begin
      LINK.phy_out <= sh[14];
    end else begin
      LINK.phy_oe  <= 1'b0;
      LINK.phy_out <= 1'b0;
    end
  end

  // ==========================================================
  // register set
  always_ff @(posedge LINK.mdc or posedge rst_link) begin
    if (rst_link) begin
      for (int i = 0; i < 32; i++) begin
        mreg[i] <= reset_value(5'(i));
      end
    end else if (commit) begin
      // read-only bits keep their value
      // gated bits open only while override is set
      mreg[regad] <= (mreg[regad] & ~(rw_mask(regad) |
                      (override ? cw_mask(regad) : mdio_pkg::RW_NONE)))
                   | (wdata & (rw_mask(regad) |
                      (override ? cw_mask(regad) : mdio_pkg::RW_NONE)));
      if (regad != mdio_pkg::REG_XCTRL) begin
        mreg[mdio_pkg::REG_XCTRL][mdio_pkg::OVR_BIT] <= 1'b0;
      end
    end
    // writes elsewhere fall through untouched
  end

  // ==========================================================
  // report events towards CLK
  // words are held until the next event, so the toggle alone
  // needs synchronising; events closer than three CLK cycles merge
  logic        rd_tog;
  logic        wr_tog;
  logic        ign_tog;
  logic [4:0]  hold_addr;
  logic [15:0] hold_data;

  always_ff @(posedge LINK.mdc or posedge rst_link) begin
    if (rst_link) begin
      rd_tog    <= 1'b0;
      wr_tog    <= 1'b0;
      ign_tog   <= 1'b0;
      hold_addr <= 5'h00;
      hold_data <= 16'h0000;
    end else if (frame_end && rd_hit) begin
      rd_tog    <= ~rd_tog;
      hold_addr <= regad;
      hold_data <= implemented(regad) ? mreg[regad] : mdio_pkg::DATA_ONES;
    end else if (commit) begin
      wr_tog    <= ~wr_tog;
      hold_addr <= regad;
      hold_data <= wdata;
    end else if (state == mdio_pkg::S_OP && bcnt == 6'h01 &&
                 op_now != mdio_pkg::OP_READ &&
                 op_now != mdio_pkg::OP_WRITE) begin
      ign_tog <= ~ign_tog;
    end
  end

  logic [2:0] rd_s;
  logic [2:0] wr_s;
  logic [2:0] ign_s;
  logic [1:0] supp_s;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_s   <= 3'h0;
      wr_s   <= 3'h0;
      ign_s  <= 3'h0;
      supp_s <= 2'h0;
    end else begin
      rd_s   <= {rd_s[1:0], rd_tog};
      wr_s   <= {wr_s[1:0], wr_tog};
      ign_s  <= {ign_s[1:0], ign_tog};
      supp_s <= {supp_s[0], suppress};
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_PULSE     <= 1'b0;
      WR_PULSE     <= 1'b0;
      IGN_PULSE    <= 1'b0;
      EV_ADDR      <= 5'h00;
      EV_DATA      <= 16'h0000;
      PREAMBLE_OFF <= 1'b0;
    end else begin
      RD_PULSE     <= rd_s[2] ^ rd_s[1];
      WR_PULSE     <= wr_s[2] ^ wr_s[1];
      IGN_PULSE    <= ign_s[2] ^ ign_s[1];
      PREAMBLE_OFF <= supp_s[1];
      if ((rd_s[2] ^ rd_s[1]) || (wr_s[2] ^ wr_s[1])) begin
        EV_ADDR <= hold_addr;
        EV_DATA <= hold_data;
      end
    end
  end

endmodule

// ### mdio_pkg.sv
// shared constants and types for the serial management link
package mdio_pkg;

  // ==========================================================
  // frame layout
  localparam int         PRE_LEN   = 32;
  localparam int         ADDR_LEN  = 5;
  localparam int         DATA_LEN  = 16;
  localparam int         HDR_LEN   = 46;
  localparam int         FRAME_LEN = 64;
  localparam logic [1:0] SFD_CODE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] TA_WRITE  = 2'h2;
  localparam logic [1:0] TA_READ   = 2'h0;

  // ==========================================================
  // register map
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STAT   = 5'h01;
  localparam logic [4:0] REG_ID1    = 5'h02;
  localparam logic [4:0] REG_ID2    = 5'h03;
  localparam logic [4:0] REG_ANADV  = 5'h04;
  localparam logic [4:0] REG_NPTX   = 5'h07;
  localparam logic [4:0] REG_XCTRL  = 5'h10;
  localparam logic [4:0] REG_TBOPS  = 5'h12;
  localparam logic [4:0] REG_XCTRL2 = 5'h13;
  // registers 0..8 and 16..19 exist
  localparam logic [31:0] IMPL_MASK = 32'h000F_01FF;

  // ==========================================================
  // field positions and masks
  localparam int          OVR_BIT   = 15;
  localparam int          SUPP_BIT  = 6;
  localparam int          PHYAD_LSB = 6;
  localparam int          PHYAD_MSB = 10;
  localparam logic [15:0] RW_ALL    = 16'hFFFF;
  localparam logic [15:0] RW_NONE   = 16'h0000;
  localparam logic [15:0] XCTRL_RW  = 16'hF83F;
  localparam logic [15:0] STAT_CW   = 16'h0040;
  localparam logic [15:0] DATA_ONES = 16'hFFFF;

  // ==========================================================
  // values after reset
  localparam logic [4:0]  PHYAD_RESET = 5'h01;
  // identifier words: arbitrary values
  localparam logic [15:0] ID1_RESET   = 16'h5A5A;
  localparam logic [15:0] ID2_RESET   = 16'hA5A0;
  localparam logic [15:0] XCTRL_RESET = {5'h00, PHYAD_RESET, 6'h00};
  localparam logic [15:0] ZERO_RESET  = 16'h0000;

  // ==========================================================
  // timing of the station's clock divider
  localparam int CLK_NS       = 8;
  localparam int MDC_HALF_NS  = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    S_IDLE, S_SFD, S_OP, S_PHYAD, S_REGAD, S_TA, S_DATA
  } phy_state_e;

endpackage

// ### mdio_sta_end.sv
// station end of the management link: frame sender with MDC divider
`timescale 1ns/1ns
module mdio_sta_end (
  // system clock domain
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // management link
  mdio_if.sta              LINK,
  // command
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_READ,
  input  wire logic        CMD_PREAMBLE,
  input  wire logic [4:0]  CMD_PHYAD,
  input  wire logic [4:0]  CMD_REGAD,
  input  wire logic [15:0] CMD_WDATA,
  output logic             CMD_READY,
  // response
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA
);

  // ==========================================================
  // line input synchroniser
  logic mdio_meta;
  logic mdio_s;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mdio_meta <= 1'b1;
      mdio_s    <= 1'b1;
    end else begin
      mdio_meta <= LINK.mdio;
      mdio_s    <= mdio_meta;
    end
  end

  // ==========================================================
  // frame sequencer
  logic [63:0] frame;
  logic [63:0] fr_new;
  logic [5:0]  idx;
  logic [5:0]  nxt;
  logic [7:0]  half;
  logic [15:0] rx;
  logic        running;
  logic        is_read;
  logic        last;

  assign fr_new = {{mdio_pkg::PRE_LEN{1'b1}}, mdio_pkg::SFD_CODE,
                   CMD_READ ? mdio_pkg::OP_READ : mdio_pkg::OP_WRITE,
                   CMD_PHYAD, CMD_REGAD,
                   CMD_READ ? mdio_pkg::TA_READ : mdio_pkg::TA_WRITE,
                   CMD_READ ? 16'h0000 : CMD_WDATA};
  assign nxt    = idx + 6'h01;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      running      <= 1'b0;
      CMD_READY    <= 1'b1;
      RSP_VALID    <= 1'b0;
      RSP_DATA     <= 16'h0000;
      LINK.mdc     <= 1'b0;
      LINK.sta_oe  <= 1'b0;
      LINK.sta_out <= 1'b0;
      frame        <= 64'h0;
      idx          <= 6'h00;
      half         <= 8'h00;
      rx           <= 16'h0000;
      is_read      <= 1'b0;
      last         <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      if (!running) begin
        if (CMD_VALID && CMD_READY) begin
          running      <= 1'b1;
          CMD_READY    <= 1'b0;
          is_read      <= CMD_READ;
          last         <= 1'b0;
          half         <= 8'h00;
          // preamble of 32 ones, or none when suppressed
          frame        <= CMD_PREAMBLE ? fr_new : {fr_new[31:0], 32'h0};
          LINK.sta_out <= CMD_PREAMBLE ? fr_new[63] : fr_new[31];
          LINK.sta_oe  <= 1'b1;
          idx          <= CMD_PREAMBLE ? 6'h00
                                       : 6'(mdio_pkg::PRE_LEN);
        end
      end else if (half != 8'(mdio_pkg::MDC_HALF_CYC - 1)) begin
        half <= half + 8'h01;
      end else begin
        half     <= 8'h00;
        LINK.mdc <= ~LINK.mdc;
        if (!LINK.mdc) begin
          // rising edge: sample the settled line
          rx   <= {rx[14:0], mdio_s};
          last <= (idx == 6'(mdio_pkg::FRAME_LEN - 1));
        end else if (last) begin
          running      <= 1'b0;
          CMD_READY    <= 1'b1;
          LINK.sta_oe  <= 1'b0;
          LINK.sta_out <= 1'b0;
          RSP_VALID    <= 1'b1;
          RSP_DATA     <= rx;
        end else begin
          // change only on the falling edge
          idx          <= nxt;
          frame        <= {frame[62:0], 1'b0};
          LINK.sta_out <= frame[62];
          // release for read turnaround and data
          LINK.sta_oe  <= !is_read || (nxt < 6'(mdio_pkg::HDR_LEN));
        end
      end
    end
  end

endmodule

// ### phy_mdio_management_slave_test.sv
// self-checking bench: station and device ends joined over the link
`timescale 1ns/1ns
module phy_mdio_management_slave_test;
  typedef struct {
    logic        rd;
    logic        pre;
    logic [4:0]  pa;
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [15:0] exp;
    logic        ev;
  } row_s;
  localparam int NROWS = 24;

  // ==========================================================
  // signals
  logic        clk;
  logic        sys_rst;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_preamble;
  logic [4:0]  cmd_phyad;
  logic [4:0]  cmd_regad;
  logic [15:0] cmd_wdata;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        rd_p;
  logic        wr_p;
  logic [4:0]  ev_addr;
  logic [15:0] ev_data;
  logic        pre_off;
  logic        rd_p2;
  logic        ign_p2;
  logic [17:0] got;
  int          err_total;
  int          n_compared;
  int          ev_cnt;
  int          rd2_cnt;
  int          ign2_cnt;
  row_s        rows [NROWS] = '{
    '{1'h0, 1'h1, 5'h03, 5'h00, 16'h1234, 16'h1234, 1'h0},
    '{1'h1, 1'h1, 5'h01, 5'h02, 16'h0000, 16'h5A5A, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h10, 16'h0000, 16'h0040, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h01, 16'h0000, 16'h0000, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h00, 16'hA5C3, 16'hA5C3, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h00, 16'h0000, 16'hA5C3, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h04, 16'hBEEF, 16'hBEEF, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h04, 16'h0000, 16'hBEEF, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h00, 16'h0000, 16'hA5C3, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h10, 16'h07C0, 16'h07C0, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h10, 16'h0000, 16'h0040, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h01, 16'h0040, 16'h0040, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h01, 16'h0000, 16'h0000, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h09, 16'h0000, 16'hFFFF, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h09, 16'h1111, 16'h1111, 1'h0},
    '{1'h1, 1'h1, 5'h01, 5'h14, 16'h0000, 16'hFFFF, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h1F, 16'h2222, 16'h2222, 1'h0},
    '{1'h0, 1'h1, 5'h01, 5'h10, 16'h8040, 16'h8040, 1'h1},
    '{1'h0, 1'h1, 5'h01, 5'h01, 16'h0040, 16'h0040, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h10, 16'h0000, 16'h0040, 1'h1},
    '{1'h1, 1'h1, 5'h01, 5'h01, 16'h0000, 16'h0040, 1'h1},
    '{1'h1, 1'h0, 5'h01, 5'h00, 16'h0000, 16'hA5C3, 1'h1},
    '{1'h0, 1'h0, 5'h01, 5'h13, 16'h0F0F, 16'h0F0F, 1'h1},
    '{1'h1, 1'h0, 5'h01, 5'h13, 16'h0000, 16'h0F0F, 1'h1}};

  // ==========================================================
  // design and checker
  mdio_if link ();
  mdio_if link2 ();

  mdio_sta_end mdio_sta_end_i (.CLK(clk), .SYS_RST(sys_rst), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_READ(cmd_read), .CMD_PREAMBLE(cmd_preamble),
    .CMD_PHYAD(cmd_phyad), .CMD_REGAD(cmd_regad), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  mdio_phy_end mdio_phy_end_i (.CLK(clk), .SYS_RST(sys_rst), .LINK(link),
    .RD_PULSE(rd_p), .WR_PULSE(wr_p), .IGN_PULSE(), .EV_ADDR(ev_addr),
    .EV_DATA(ev_data), .PREAMBLE_OFF(pre_off));
  // second device faces a bench driver that breaks framing on purpose
  mdio_phy_end mdio_phy_end_i2 (.CLK(clk), .SYS_RST(sys_rst), .LINK(link2),
    .RD_PULSE(rd_p2), .WR_PULSE(), .IGN_PULSE(ign_p2), .EV_ADDR(),
    .EV_DATA(), .PREAMBLE_OFF());
  mdio_link_props mdio_link_props_i (.CLK(clk), .SYS_RST(sys_rst),
    .mdc(link.mdc), .sta_out(link.sta_out), .sta_oe(link.sta_oe),
    .phy_out(link.phy_out), .phy_oe(link.phy_oe), .mdio(link.mdio));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    ev_cnt   <= ev_cnt + (rd_p === 1'h1) + (wr_p === 1'h1);
    rd2_cnt  <= rd2_cnt + (rd_p2 === 1'h1);
    ign2_cnt <= ign2_cnt + (ign_p2 === 1'h1);
  end

  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [17:0] e,
                       input logic [17:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_row(input row_s r);
    int n;
    int ev0;
    ev0 = ev_cnt;
    @(posedge clk);
    cmd_valid    <= 1'h1;
    cmd_read     <= r.rd;
    cmd_preamble <= r.pre;
    cmd_phyad    <= r.pa;
    cmd_regad    <= r.ra;
    cmd_wdata    <= r.wd;
    @(posedge clk);
    while (cmd_ready !== 1'h1) @(posedge clk);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 4000);
    check("rsp_valid", 18'h1, 18'(rsp_valid));
    check("rsp_data", 18'(r.exp), 18'(rsp_data));
    repeat (2) @(posedge clk);
    check("events", 18'(r.ev), 18'(ev_cnt - ev0));
    if (r.ev) begin
      check("ev_addr", 18'(r.ra), 18'(ev_addr));
      check("ev_data", 18'(r.exp), 18'(ev_data));
    end
  endtask

  // one bit on the second link: change after fall, sample before rise
  task automatic bit2(input logic oe, input logic b, output logic s);
    link2.sta_oe  = oe;
    link2.sta_out = b;
    #62;
    s = link2.mdio;
    link2.mdc = 1'h1;
    #63;
    link2.mdc = 1'h0;
  endtask

  task automatic frame2(input int npre, input logic [1:0] sfd,
                        input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd);
    logic [13:0] hdr;
    logic [17:0] word;
    logic        rd;
    logic        s;
    hdr  = {sfd, op, mdio_pkg::PHYAD_RESET, ra};
    rd   = (op == mdio_pkg::OP_READ);
    word = rd ? 18'h3FFFF : {mdio_pkg::TA_WRITE, wd};
    for (int i = 0; i < npre; i++) bit2(1'h1, 1'h1, s);
    for (int i = 13; i >= 0; i--) bit2(1'h1, hdr[i], s);
    for (int i = 17; i >= 0; i--) begin
      bit2(!rd, word[i], s);
      got[i] = s;
    end
    link2.sta_oe = 1'h0;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (98000) @(posedge clk);
    err_total++;
    $display("BAD run_time expected done seen hang");
    final_report();
  end

  initial begin
    sys_rst = 1'h1;
    {cmd_valid, cmd_read, cmd_preamble} = 3'h0;
    {cmd_phyad, cmd_regad, cmd_wdata} = 26'h0;
    {link2.mdc, link2.sta_out, link2.sta_oe} = 3'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    for (int i = 0; i < NROWS; i++) do_row(rows[i]);
    check("preamble_off", 18'h1, 18'(pre_off));
    frame2(34, mdio_pkg::SFD_CODE, 2'h0, 5'h00, 16'h0000);
    frame2(32, mdio_pkg::SFD_CODE, 2'h3, 5'h00, 16'h0000);
    check("ignored", 18'h2, 18'(ign2_cnt));
    frame2(31, mdio_pkg::SFD_CODE, mdio_pkg::OP_READ, 5'h02, 16'h0000);
    check("short_pre", 18'h0, 18'(rd2_cnt));
    check("short_pre_line", 18'h3FFFF, got);
    frame2(32, 2'h0, mdio_pkg::OP_WRITE, 5'h00, 16'h5555);
    frame2(32, mdio_pkg::SFD_CODE, mdio_pkg::OP_WRITE, 5'h04, 16'h1357);
    frame2(32, mdio_pkg::SFD_CODE, mdio_pkg::OP_READ, 5'h00, 16'h0000);
    check("bad_start", {2'h2, 16'h0000}, got);
    frame2(32, mdio_pkg::SFD_CODE, mdio_pkg::OP_READ, 5'h04, 16'h0000);
    check("read2", {2'h2, 16'h1357}, got);
    sys_rst <= 1'h1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    check("preamble_off", 18'h0, 18'(pre_off));
    do_row('{1'h0, 1'h1, 5'h03, 5'h00, 16'h0000, 16'h0000, 1'h0});
    do_row('{1'h1, 1'h1, 5'h01, 5'h00, 16'h0000, 16'h0000, 1'h1});
    do_row('{1'h1, 1'h0, 5'h01, 5'h00, 16'h0000, 16'hFFFF, 1'h0});
    final_report();
  end
endmodule
